// ==== rtl/ced_detector.sv ====
// Configuration-memory CRC error detector with error flag and message.
`include "ced_map.svh"
module ced_detector
  import ced_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   user_mode,
  input  wire logic                   detect_enable,
  input  wire logic [3:0]             div_exp,
  input  wire logic                   cfg_wr_en,
  input  wire logic [13:0]            cfg_wr_addr,
  input  wire logic [`CED_WORD_W-1:0] cfg_wr_data,
  output logic                        crc_error,
  output logic                        crc_error_pin,
  output logic                        crc_error_pin_oe,
  output logic      [`CED_MSG_W-1:0]  error_msg,
  output logic                        running,
  output logic                        pass_done,
  output logic                        exp_invalid
);
  ced_state_t state_q, state_d;
  logic [3:0]             exp_q;
  logic                   exp_ok;
  logic [8:0]             div_cnt_q;
  logic                   tick;
  logic [15:0]            word_q;
  logic [15:0]            frame_q;
  logic [15:0]            crc_q;
  logic [15:0]            stored_crc_q;
  logic [15:0]            syndrome;
  logic [15:0]            syn_q;
  logic [15:0]            err_frame_q;
  logic [7:0]             cnt_q;
  logic [15:0]            upd_q;
  logic                   upd_ok;
  logic [`CED_WORD_W-1:0] rd_data;
  logic [13:0]            rd_addr;
  logic                   last_word;
  logic                   last_frame;
  logic [1:0]             err_type;
  logic                   flag_q;
  logic [`CED_MSG_W-1:0]  msg_q;
  logic                   done_q;

  // One bit of the frame CRC step, applied over a whole word.
  function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [31:0] w);
    logic [15:0] r;
    r = c;
    for (int i = 31; i >= 0; i--)
    begin
      r = {r[14:0], 1'b0} ^ ((r[15] ^ w[i]) ? `CED_CRC_POLY : 16'h0000);
    end
    return r;
  endfunction

  // Exponent range check.
  // Valid divisor range.
  assign exp_ok = (exp_q >= `CED_N_MIN) && (exp_q <= `CED_N_MAX);
  assign exp_invalid = ~exp_ok;

  // The 125 MHz core clock stands in for the oscillator; the enable fires once per 2^n clocks.
  // Power-of-two divider.
  assign tick = exp_ok && ((div_cnt_q & ((9'h001 << exp_q) - 9'h001)) == 9'h000);

  assign rd_addr = 14'(frame_q * `CED_FRAME_WORDS + word_q);
  assign last_word = (word_q == `CED_FRAME_WORDS - 16'h0001);
  assign last_frame = (frame_q == `CED_FRAME_COUNT - 16'h0001);
  assign syndrome = crc_q ^ stored_crc_q;
  // Locations are only meaningful for single or adjacent double upsets.
  // Error classification.
  assign err_type = ($countones(syn_q) == 1) ? `CED_TYPE_SINGLE :
                    ($countones(syn_q) == 2) ? `CED_TYPE_DOUBLE : `CED_TYPE_OTHER;
  assign upd_ok = (upd_q == 16'h0000);

  ced_frame_mem u_mem
  (
    .core_clk (core_clk),
    .wr_en    (cfg_wr_en),
    .wr_addr  (cfg_wr_addr),
    .wr_data  (cfg_wr_data),
    .rd_addr  (rd_addr),
    .rd_data  (rd_data)
  );

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      CED_IDLE:   state_d = (user_mode && detect_enable && exp_ok) ? CED_DATA : CED_IDLE;
      CED_DATA:   state_d = (tick && last_word) ? CED_CHECK : CED_DATA;
      CED_CHECK:  state_d = !tick ? CED_CHECK :
                            (syndrome != 16'h0000) ? CED_SEARCH : CED_DATA;
      CED_SEARCH: state_d = (tick && cnt_q == 8'h00 && upd_ok) ? CED_REPORT : CED_SEARCH;
      CED_REPORT: state_d = tick ? CED_GAP : CED_REPORT;
      CED_GAP:    state_d = (tick && cnt_q == 8'h00) ? CED_DATA : CED_GAP;
      default:    state_d = CED_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      exp_q <= `CED_N_DEFAULT;
      div_cnt_q <= 9'h000;
      state_q <= CED_IDLE;
      word_q <= 16'h0000;
      frame_q <= 16'h0000;
      crc_q <= `CED_CRC_INIT;
      stored_crc_q <= 16'h0000;
      syn_q <= 16'h0000;
      err_frame_q <= 16'h0000;
      cnt_q <= 8'h00;
      upd_q <= 16'h0000;
      flag_q <= 1'b0;
      msg_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      if (state_q == CED_IDLE)
      begin
        exp_q <= div_exp;
      end
      div_cnt_q <= div_cnt_q + 9'h001;
      state_q <= state_d;
      done_q <= 1'b0;
      if (upd_q != 16'h0000)
      begin
        upd_q <= upd_q - 16'h0001;
      end
      if (tick)
      begin
        case (state_q)
          CED_DATA:
          begin
            // The last word of each frame carries its precomputed CRC.
            if (last_word)
            begin
              stored_crc_q <= rd_data[15:0];
              word_q <= 16'h0000;
            end
            else
            begin
              crc_q <= crc_word(crc_q, rd_data);
              word_q <= word_q + 16'h0001;
            end
          end
          CED_CHECK:
          begin
            // The CRC restarts for the next frame here, so the report keeps its own copy.
            syn_q <= syndrome;
            err_frame_q <= frame_q;
            cnt_q <= `CED_SEARCH_CYC;
            crc_q <= `CED_CRC_INIT;
            frame_q <= last_frame ? 16'h0000 : frame_q + 16'h0001;
            done_q <= last_frame;
          end
          CED_SEARCH:
          begin
            if (cnt_q != 8'h00)
            begin
              cnt_q <= cnt_q - 8'h01;
            end
            else if (upd_ok)
            begin
              msg_q <= {err_type, 28'(err_frame_q), syn_q};
              upd_q <= 16'(`CED_MIN_UPD_CYC);
            end
          end
          CED_REPORT:
          begin
            flag_q <= 1'b1;
            cnt_q <= `CED_LOW_GAP;
          end
          CED_GAP:
          begin
            flag_q <= 1'b0;
            if (cnt_q != 8'h00)
            begin
              cnt_q <= cnt_q - 8'h01;
            end
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  assign running = (state_q != CED_IDLE);
  assign crc_error = flag_q;
  assign crc_error_pin = flag_q;
  assign crc_error_pin_oe = detect_enable;
  assign error_msg = msg_q;
  assign pass_done = done_q;
endmodule

// ==== rtl/ced_map.svh ====
// Constants for the configuration CRC error detector.
`ifndef CED_MAP_SVH
`define CED_MAP_SVH
`define CED_OSC_MHZ        100
`define CED_CLK_MHZ        125
`define CED_N_MIN          4'h1
`define CED_N_MAX          4'h8
`define CED_N_DEFAULT      4'h1
`define CED_LOW_GAP        8'h20
`define CED_MIN_UPD_US     15
`define CED_MIN_UPD_CYC    ((`CED_MIN_UPD_US * `CED_CLK_MHZ))
`define CED_MSG_W          46
`define CED_SYN_W          16
`define CED_LOC_W          28
`define CED_TYPE_W         2
`define CED_WORD_W         32
`define CED_FRAME_WORDS    16'h0040
`define CED_FRAME_COUNT    16'h0100
`define CED_CRC_POLY       16'h1021
`define CED_CRC_INIT       16'hffff
`define CED_TYPE_NONE      2'h0
`define CED_TYPE_SINGLE    2'h1
`define CED_TYPE_DOUBLE    2'h2
`define CED_TYPE_OTHER     2'h3
`define CED_SEARCH_CYC     8'h10
`endif

// ==== rtl/ced_pkg.sv ====
// Types for the configuration CRC error detector.
package ced_pkg;
  typedef enum logic [5:0]
  {
    CED_IDLE   = 6'h01,
    CED_DATA   = 6'h02,
    CED_CHECK  = 6'h04,
    CED_SEARCH = 6'h08,
    CED_REPORT = 6'h10,
    CED_GAP    = 6'h20
  } ced_state_t;
endpackage

// ==== rtl/ced_frame_mem.sv ====
// Configuration frame store with registered read data.
`include "ced_map.svh"
module ced_frame_mem
  import ced_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   wr_en,
  input  wire logic [13:0]            wr_addr,
  input  wire logic [`CED_WORD_W-1:0] wr_data,
  input  wire logic [13:0]            rd_addr,
  output logic      [`CED_WORD_W-1:0] rd_data
);
  logic [`CED_WORD_W-1:0] mem [0:16383];

  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// ==== dv/ced_props.sv ====
// Port-level timing checks for the CRC error detector.
`include "ced_map.svh"
module ced_props
(
  input wire logic                  core_clk,
  input wire logic                  rst,
  input wire logic                  user_mode,
  input wire logic                  detect_enable,
  input wire logic [3:0]            div_exp,
  input wire logic                  crc_error,
  input wire logic                  crc_error_pin,
  input wire logic                  crc_error_pin_oe,
  input wire logic [`CED_MSG_W-1:0] error_msg,
  input wire logic                  running,
  input wire logic                  pass_done,
  input wire logic                  exp_invalid
);
  logic [7:0]  gap_q;
  logic [11:0] upd_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Saturating counters, so a long quiet run never wraps into a false short gap.
  always_ff @(posedge core_clk)
  begin
    gap_q <= (rst || !$fell(crc_error)) ? (rst ? 8'hff : gap_q + {7'h0, gap_q != 8'hff}) : 8'h0;
    upd_q <= (rst || !$changed(error_msg)) ? (rst ? 12'hfff : upd_q + {11'h0, upd_q != 12'hfff})
                                           : 12'h0;
  end
  chk_pin_copy: assert property (crc_error_pin == crc_error) else $error("pin differs");
  chk_oe_enable: assert property (crc_error_pin_oe == detect_enable) else $error("oe bad");
  chk_low_gap: assert property ($rose(crc_error) |-> gap_q >= `CED_LOW_GAP)
    else $error("gap short");
  chk_msg_first: assert property ($rose(crc_error) |-> $stable(error_msg))
    else $error("late msg");
  chk_syn_nonzero: assert property (crc_error |-> error_msg[15:0] != 16'h0)
    else $error("zero syndrome");
  chk_upd_spacing: assert property ($changed(error_msg) |-> upd_q >= `CED_MIN_UPD_CYC)
    else $error("updates too close");
  chk_exp_range: assert property (!running |=> exp_invalid ==
    ($past(div_exp) < `CED_N_MIN || $past(div_exp) > `CED_N_MAX))
    else $error("exponent check");
  chk_exp_static: assert property (running |=> $stable(exp_invalid))
    else $error("exponent moved");
  chk_auto_start: assert property (!running && user_mode && detect_enable && !exp_invalid
    |=> running) else $error("no start");
  chk_keep_running: assert property (running |=> running) else $error("stopped");
  cover property ($rose(running));
  cover property ($rose(crc_error));
  cover property ($changed(error_msg));
  cover property (pass_done);
endmodule

// ==== dv/ced_monitor.sv ====
// System-side monitor that unloads each error report and asks for recovery.
module ced_monitor
(
  input  wire logic        core_clk,
  input  wire logic        crc_error,
  input  wire logic [45:0] error_msg,
  output int               reports,
  output logic [45:0]      last_msg,
  output logic             reconfig_request_n
);
  logic flag_q;
  initial
  begin
    reports = 0;
    flag_q = 1'b1;
    reconfig_request_n = 1'b1;
  end
  always @(posedge core_clk)
  begin
    flag_q <= crc_error;
    reconfig_request_n <= 1'b1;
    if (crc_error === 1'b1 && flag_q === 1'b0)
    begin
      reports <= reports + 1;
      last_msg <= error_msg;
      reconfig_request_n <= 1'b0;
    end
  end
endmodule

// ==== dv/tb.sv ====
// Self-checking bench for the CRC error detector.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 0, rst = 1, user_mode = 0, detect_enable = 0, cfg_wr_en = 0;
  logic [3:0]  div_exp = 4'h1;
  logic [13:0] cfg_wr_addr = 14'h0;
  logic [31:0] cfg_wr_data = 32'h0;
  logic        crc_error, crc_error_pin, crc_error_pin_oe, running, pass_done, exp_invalid;
  logic        reconfig_request_n;
  logic [45:0] error_msg, last_msg;
  logic [15:0] good, bad [3];
  int          errors = 0, cmp_count = 0, reports;
  always #4 core_clk = ~core_clk;
  ced_detector i_dut(.core_clk(core_clk), .rst(rst), .user_mode(user_mode),
    .detect_enable(detect_enable), .div_exp(div_exp), .cfg_wr_en(cfg_wr_en),
    .cfg_wr_addr(cfg_wr_addr), .cfg_wr_data(cfg_wr_data), .crc_error(crc_error),
    .crc_error_pin(crc_error_pin), .crc_error_pin_oe(crc_error_pin_oe), .error_msg(error_msg),
    .running(running), .pass_done(pass_done), .exp_invalid(exp_invalid));
  ced_monitor i_mon(.core_clk(core_clk), .crc_error(crc_error), .error_msg(error_msg),
    .reports(reports), .last_msg(last_msg), .reconfig_request_n(reconfig_request_n));
  function automatic logic [15:0] zero_crc();
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 0; i < 63 * 32; i++)
      c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
    return c;
  endfunction
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [1:0] etype(input logic [15:0] s);
    return ($countones(s) == 1) ? 2'h1 : ($countones(s) == 2) ? 2'h2 : 2'h3;
  endfunction
  task automatic chk(input logic [43:0] got, input logic [43:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wait_rep(input int k);
    int n;
    n = 0;
    while (reports < k && n < 20000)
    begin
      @(negedge core_clk);
      n++;
    end
    if (reports < k)
    begin
      errors++;
      $display("unexpected at %0t: no report", $time);
      final_report();
    end
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (pass_done !== 1'b1 && n < 72000)
    begin
      @(negedge core_clk);
      n++;
    end
    chk(44'(pass_done), 44'h1);
  endtask
  initial
  begin
    void'($urandom(32'hd700));
    for (int i = 0; i < 3; i++)
      bad[i] = 16'($urandom_range(16'hffff, 1));
    good = zero_crc();
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    detect_enable = 1'b1;
    // Zero data everywhere; frames 1 and 2 carry a corrupted check word.
    for (int a = 0; a < 16384; a++)
    begin
      cfg_wr_en = 1'b1;
      cfg_wr_addr = 14'(a);
      cfg_wr_data = (a % 64 != 63) ? 32'h0 : {16'h0, good ^ ((a / 64 == 1 || a / 64 == 2)
                    ? bad[a / 64] : 16'h0)};
      @(negedge core_clk);
    end
    cfg_wr_en = 1'b0;
    chk(44'(running), 44'h0);
    chk(44'(crc_error_pin_oe), 44'h1);
    for (int n = 0; n < 16; n++)
    begin
      div_exp = 4'(n);
      // The exponent is registered, so the flag follows one clock edge later.
      @(negedge core_clk);
      chk(44'(exp_invalid), 44'(n < 1 || n > 8));
    end
    div_exp = 4'(1 + $urandom % 2);
    user_mode = 1'b1;
    $display("idle and exponent test done");
    wait_rep(1);
    chk(last_msg[43:0], {28'h1, bad[1]});
    chk(44'(last_msg[45:44]), 44'(etype(bad[1])));
    wait_rep(2);
    chk(last_msg[43:0], {28'h2, bad[2]});
    chk(44'(running), 44'h1);
    $display("report test done");
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    chk({42'(error_msg), running, crc_error}, 44'h0);
    wait_rep(3);
    chk(last_msg[43:0], {28'h1, bad[1]});
    $display("restart test done");
    wait_done();
    chk(44'(reports), 44'h4);
    $display("full pass test done");
    final_report();
  end
endmodule
bind ced_detector ced_props i_props(.core_clk(core_clk), .rst(rst), .user_mode(user_mode),
  .detect_enable(detect_enable), .div_exp(div_exp), .crc_error(crc_error),
  .crc_error_pin(crc_error_pin), .crc_error_pin_oe(crc_error_pin_oe), .error_msg(error_msg),
  .running(running), .pass_done(pass_done), .exp_invalid(exp_invalid));
